// ---- acc_config_control.sv ----
// Converter configuration registers over AXI4-Lite and the sample path.
// Assumes one clock; sample input and pins are synchronous to aclk.
//
// Contract
// - Software reset restores every default like hardware reset, self clearing.
// - Global power down bit powers whole converter down; resets to 0.
// - Standby bit puts all channels into standby; resets to 0.
// - Configuration picks power-down pin effect: global down or standby.
// - Format bit: 0 two's complement, 1 offset binary; resets 0.
// - Frame-reference buffer disable bit; reset 0 keeps buffer enabled.
// - Programmable divider derives sample rate from the input clock.
// - Per-channel dither on by default; disable bit turns it off.
// - Per-channel power down affects only that channel.
// - Per-channel gain enable switches digital gain into the path.
// - Per-channel gain setting spans 0 dB to 6 dB.
// - Test pattern enable replaces sample data with patterns.
// - Per-channel selector chooses pattern, normal operation included.
// - Align control makes test data on all outputs aligned.
// - Programmable 14-bit custom word output when custom pattern chosen.
// - Per-channel chopper on by default, moves noise to Fs/2; disable bit.
// - Low-frequency mode control for sample rates below 35 MHz.
// - Over-range on LSB option replaces LSB with over-range flag.
// - Multi-bit field sets serial output swing.
`include "acc_defs.svh"
module acc_config_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pushbutton,
  input wire logic power_down_pin,
  input wire logic [`ACC_NCH*`ACC_SW-1:0] sample_in,
  input wire logic [`ACC_NCH-1:0] over_range_flag,
  output logic sample_en,
  output logic [`ACC_NCH*`ACC_SW-1:0] sample_out,
  output logic [`ACC_NCH-1:0] sample_valid,
  output logic [`ACC_NCH-1:0] dither_en,
  output logic [`ACC_NCH-1:0] chopper_en,
  output logic [`ACC_NCH-1:0] chan_powered,
  output logic chip_power_down,
  output logic frame_ref_buffer_disable,
  output logic low_freq_mode,
  output logic [7:0] lvds_swing
);
  acc_pkg::acc_chan_t chan_q [`ACC_NCH];
  acc_pkg::acc_glob_t glob_q;
  logic sw_reset_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [`ACC_DIV_W-1:0] div_cnt_q;
  logic [`ACC_SW-1:0] ramp_q;
  logic toggle_q;
  logic cfg_rst;
  logic do_write;
  logic pin_gpd, pin_stby, chip_off, all_stby;

  // Pushbutton, bus reset and the self-clearing soft reset act alike
  assign cfg_rst = !aresetn || reset_pushbutton || sw_reset_q;
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  // Pin effect steered by configuration
  assign pin_gpd = power_down_pin && !glob_q.pin_to_standby;
  assign pin_stby = power_down_pin && glob_q.pin_to_standby;
  assign chip_off = glob_q.global_pd || pin_gpd;
  assign all_stby = glob_q.standby || pin_stby;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] chan_word(input acc_pkg::acc_chan_t c);
    logic [31:0] r;
    r = 32'h0;
    r[`ACC_B_DITHOFF] = c.dither_off;
    r[`ACC_B_CHPD] = c.power_down;
    r[`ACC_B_GAINEN] = c.gain_en;
    r[`ACC_B_CHOPOFF] = c.chop_off;
    r[`ACC_GAIN_HI:`ACC_GAIN_LO] = c.gain_db;
    r[`ACC_PAT_HI:`ACC_PAT_LO] = c.pattern;
    return r;
  endfunction

  // Gain in roughly 1 dB steps as Q1.8 multipliers, clamped to 6 dB
  function automatic logic [9:0] gain_mult(input logic [2:0] db);
    case (db)
      3'h0: return 10'h100;
      3'h1: return 10'h11f;
      3'h2: return 10'h143;
      3'h3: return 10'h16a;
      3'h4: return 10'h196;
      3'h5: return 10'h1c7;
      default: return 10'h1fe;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q > `ACC_OFF_MISC || aw_addr_q[1:0] != 2'h0)
                     ? `ACC_RESP_SLVERR : `ACC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Soft reset bit reads back 0: it is high for one cycle only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= do_write && aw_addr_q == `ACC_OFF_GLOBAL &&
                    w_strb_q[0] && w_data_q[`ACC_B_SWRST] && !sw_reset_q;
    end
  end

  always_ff @(posedge aclk) begin
    logic [31:0] m;
    m = 32'h0;
    if (cfg_rst) begin
      glob_q <= '0;
      for (int i = 0; i < `ACC_NCH; i++) begin
        chan_q[i] <= '0;
      end
    end else if (do_write) begin
      if (aw_addr_q == `ACC_OFF_GLOBAL) begin
        m = merge({26'h0, glob_q.frame_ref_buffer_disable,
                   glob_q.offset_binary, glob_q.pin_to_standby,
                   glob_q.standby, glob_q.global_pd, 1'b0},
                  w_data_q, w_strb_q);
        glob_q.global_pd <= m[`ACC_B_GPD];
        glob_q.standby <= m[`ACC_B_STBY];
        glob_q.pin_to_standby <= m[`ACC_B_PINSTBY];
        glob_q.offset_binary <= m[`ACC_B_FMT];
        glob_q.frame_ref_buffer_disable <= m[`ACC_B_FRBUF];
      end else if (aw_addr_q == `ACC_OFF_CLKDIV) begin
        m = merge({29'h0, glob_q.clk_div}, w_data_q, w_strb_q);
        glob_q.clk_div <= m[`ACC_DIV_W-1:0];
      end else if (aw_addr_q == `ACC_OFF_CHAN0 ||
                   aw_addr_q == `ACC_OFF_CHAN1) begin
        for (int i = 0; i < `ACC_NCH; i++) begin
          if (aw_addr_q[2] == i[0]) begin
            m = merge(chan_word(chan_q[i]), w_data_q, w_strb_q);
            chan_q[i].dither_off <= m[`ACC_B_DITHOFF];
            chan_q[i].power_down <= m[`ACC_B_CHPD];
            chan_q[i].gain_en <= m[`ACC_B_GAINEN];
            chan_q[i].chop_off <= m[`ACC_B_CHOPOFF];
            // Out-of-range gain codes are clamped to 6 dB
            chan_q[i].gain_db <= (m[`ACC_GAIN_HI:`ACC_GAIN_LO] >
                                  `ACC_GAIN_MAX) ? `ACC_GAIN_MAX :
                                 m[`ACC_GAIN_HI:`ACC_GAIN_LO];
            chan_q[i].pattern <= acc_pkg::acc_pat_t'(
                                 m[`ACC_PAT_HI:`ACC_PAT_LO]);
          end
        end
      end else if (aw_addr_q == `ACC_OFF_TEST) begin
        m = merge({14'h0, glob_q.test_align, glob_q.test_en, 2'h0,
                   glob_q.custom_word}, w_data_q, w_strb_q);
        glob_q.custom_word <= m[`ACC_SW-1:0];
        glob_q.test_en <= m[`ACC_B_TPEN];
        glob_q.test_align <= m[`ACC_B_ALIGN];
      end else if (aw_addr_q == `ACC_OFF_MISC) begin
        m = merge({16'h0, glob_q.lvds_swing, 6'h0, glob_q.over_range_lsb,
                   glob_q.low_freq_mode}, w_data_q, w_strb_q);
        glob_q.low_freq_mode <= m[`ACC_B_LFM];
        glob_q.over_range_lsb <= m[`ACC_B_OVRLSB];
        glob_q.lvds_swing <= m[`ACC_SWING_HI:`ACC_SWING_LO];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ACC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ACC_RESP_OKAY;
      if (s_axi_araddr == `ACC_OFF_GLOBAL) begin
        s_axi_rdata <= {26'h0, glob_q.frame_ref_buffer_disable,
                        glob_q.offset_binary, glob_q.pin_to_standby,
                        glob_q.standby, glob_q.global_pd, 1'b0};
      end else if (s_axi_araddr == `ACC_OFF_CLKDIV) begin
        s_axi_rdata <= {29'h0, glob_q.clk_div};
      end else if (s_axi_araddr == `ACC_OFF_CHAN0) begin
        s_axi_rdata <= chan_word(chan_q[0]);
      end else if (s_axi_araddr == `ACC_OFF_CHAN1) begin
        s_axi_rdata <= chan_word(chan_q[1]);
      end else if (s_axi_araddr == `ACC_OFF_TEST) begin
        s_axi_rdata <= {14'h0, glob_q.test_align, glob_q.test_en, 2'h0,
                        glob_q.custom_word};
      end else if (s_axi_araddr == `ACC_OFF_MISC) begin
        s_axi_rdata <= {16'h0, glob_q.lvds_swing, 6'h0, glob_q.over_range_lsb,
                        glob_q.low_freq_mode};
      end else if (s_axi_araddr == `ACC_OFF_STATUS) begin
        s_axi_rdata <= {28'h0, all_stby, chip_off, chan_powered};
      end else if (s_axi_araddr == `ACC_OFF_SAMPLE) begin
        s_axi_rdata <= {4'h0, sample_out};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `ACC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Divide by clk_div+1; code 0 samples every cycle
  always_ff @(posedge aclk) begin
    if (cfg_rst) begin
      div_cnt_q <= '0;
      sample_en <= 1'b0;
    end else if (div_cnt_q >= glob_q.clk_div) begin
      div_cnt_q <= '0;
      sample_en <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
      sample_en <= 1'b0;
    end
  end

  // One shared ramp and toggle keep all channels in step
  always_ff @(posedge aclk) begin
    if (cfg_rst || !glob_q.test_en ||
        (glob_q.test_align && do_write && aw_addr_q == `ACC_OFF_TEST)) begin
      ramp_q <= '0;
      toggle_q <= 1'b0;
    end else if (sample_en) begin
      ramp_q <= ramp_q + 1'b1;
      toggle_q <= !toggle_q;
    end
  end

  always_ff @(posedge aclk) begin
    logic [`ACC_SW-1:0] s;
    logic [`ACC_SW+9:0] p;
    s = '0;
    p = '0;
    if (cfg_rst) begin
      sample_out <= '0;
      sample_valid <= '0;
    end else if (sample_en) begin
      for (int i = 0; i < `ACC_NCH; i++) begin
        s = sample_in[i*`ACC_SW +: `ACC_SW];
        if (chan_q[i].gain_en) begin
          p = {{10{s[`ACC_SW-1]}}, s} *
              {{`ACC_SW{1'b0}}, gain_mult(chan_q[i].gain_db)};
          s = p[`ACC_SW+7:8];
        end
        if (glob_q.offset_binary) begin
          s[`ACC_SW-1] = !s[`ACC_SW-1];
        end
        if (glob_q.over_range_lsb) begin
          s[0] = over_range_flag[i];
        end
        if (glob_q.test_en) begin
          case (chan_q[i].pattern)
            acc_pkg::ACC_PAT_ZEROS: s = '0;
            acc_pkg::ACC_PAT_ONES: s = '1;
            acc_pkg::ACC_PAT_TOGGLE: s = {(`ACC_SW/2){toggle_q, !toggle_q}};
            acc_pkg::ACC_PAT_RAMP: s = ramp_q;
            acc_pkg::ACC_PAT_CUSTOM: s = glob_q.custom_word;
            default: s = s;
          endcase
        end
        if (!chan_powered[i]) begin
          s = '0;
        end
        sample_out[i*`ACC_SW +: `ACC_SW] <= s;
        sample_valid[i] <= chan_powered[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (cfg_rst) begin
      dither_en <= '1;
      chopper_en <= '1;
      chan_powered <= '0;
      chip_power_down <= 1'b0;
      frame_ref_buffer_disable <= 1'b0;
      low_freq_mode <= 1'b0;
      lvds_swing <= '0;
    end else begin
      for (int i = 0; i < `ACC_NCH; i++) begin
        dither_en[i] <= !chan_q[i].dither_off;
        chopper_en[i] <= !chan_q[i].chop_off;
        // Other channels keep running
        chan_powered[i] <= !chan_q[i].power_down && !chip_off && !all_stby;
      end
      chip_power_down <= chip_off;
      frame_ref_buffer_disable <= glob_q.frame_ref_buffer_disable;
      low_freq_mode <= glob_q.low_freq_mode;
      lvds_swing <= glob_q.lvds_swing;
    end
  end

  property p_swrst_clears;
    @(posedge aclk) disable iff (!aresetn)
      sw_reset_q |=> !sw_reset_q && glob_q == '0;
  endproperty
  a_swrst_clears: assert property (p_swrst_clears)
    else $error("soft reset did not restore defaults");

  property p_gpd;
    @(posedge aclk) disable iff (!aresetn)
      (glob_q.global_pd && !cfg_rst) |=> chip_power_down &&
        chan_powered == '0;
  endproperty
  a_gpd: assert property (p_gpd)
    else $error("global power down not applied");

  property p_stby;
    @(posedge aclk) disable iff (!aresetn)
      (glob_q.standby && !cfg_rst) |=> chan_powered == '0;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby did not stop channels");

  property p_pin;
    @(posedge aclk) disable iff (!aresetn || cfg_rst)
      (power_down_pin && glob_q.pin_to_standby && !glob_q.global_pd)
        |=> !chip_power_down;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin in standby mode powered chip down");

  property p_div;
    @(posedge aclk) disable iff (cfg_rst)
      (sample_en && glob_q.clk_div != 3'h0 && !do_write) |=> !sample_en;
  endproperty
  a_div: assert property (p_div)
    else $error("divider pulse spacing wrong");

  property p_dither;
    @(posedge aclk) disable iff (cfg_rst)
      chan_q[0].dither_off |=> !dither_en[0];
  endproperty
  a_dither: assert property (p_dither)
    else $error("dither stayed on");

  property p_chop;
    @(posedge aclk) disable iff (cfg_rst)
      !chan_q[1].chop_off |=> chopper_en[1];
  endproperty
  a_chop: assert property (p_chop)
    else $error("chopper off without request");

  property p_custom;
    @(posedge aclk) disable iff (cfg_rst)
      (sample_en && glob_q.test_en && chan_powered[0] &&
       chan_q[0].pattern == acc_pkg::ACC_PAT_CUSTOM)
        |=> sample_out[`ACC_SW-1:0] == $past(glob_q.custom_word);
  endproperty
  a_custom: assert property (p_custom)
    else $error("custom word not output");

  property p_unity;
    @(posedge aclk) disable iff (cfg_rst)
      (sample_en && !glob_q.test_en && !glob_q.offset_binary &&
       !glob_q.over_range_lsb && !chan_q[0].gain_en && chan_powered[0])
        |=> sample_out[`ACC_SW-1:0] == $past(sample_in[`ACC_SW-1:0]);
  endproperty
  a_unity: assert property (p_unity)
    else $error("gain applied while gain stage off");

  c_swrst: cover property (@(posedge aclk) disable iff (!aresetn)
    sw_reset_q);
  c_custom: cover property (@(posedge aclk) disable iff (cfg_rst)
    sample_en && glob_q.test_en &&
    chan_q[0].pattern == acc_pkg::ACC_PAT_CUSTOM);
  c_gain: cover property (@(posedge aclk) disable iff (cfg_rst)
    sample_en && chan_q[0].gain_en && chan_q[0].gain_db == `ACC_GAIN_MAX);
endmodule // acc_config_control

// ---- acc_defs.svh ----
// Constants for the converter configuration and control block.
// Assumes inclusion by bare name; definitions only.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
`define ACC_NCH 2
`define ACC_SW 14
`define ACC_OFF_GLOBAL 8'h00
`define ACC_OFF_CLKDIV 8'h04
`define ACC_OFF_CHAN0 8'h08
`define ACC_OFF_CHAN1 8'h0c
`define ACC_OFF_TEST 8'h10
`define ACC_OFF_MISC 8'h14
`define ACC_OFF_STATUS 8'h18
`define ACC_OFF_SAMPLE 8'h1c
`define ACC_B_SWRST 0
`define ACC_B_GPD 1
`define ACC_B_STBY 2
`define ACC_B_PINSTBY 3
`define ACC_B_FMT 4
`define ACC_B_FRBUF 5
`define ACC_B_DITHOFF 0
`define ACC_B_CHPD 1
`define ACC_B_GAINEN 2
`define ACC_B_CHOPOFF 3
`define ACC_GAIN_LO 4
`define ACC_GAIN_HI 6
`define ACC_PAT_LO 8
`define ACC_PAT_HI 10
`define ACC_B_TPEN 16
`define ACC_B_ALIGN 17
`define ACC_B_LFM 0
`define ACC_B_OVRLSB 1
`define ACC_SWING_LO 8
`define ACC_SWING_HI 15
`define ACC_GAIN_MAX 3'h6
`define ACC_DIV_W 3
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2
`endif

// ---- acc_pkg.sv ----
// Types for the converter configuration and control block.
// Assumes acc_defs.svh constants.
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_PAT_NORMAL, ACC_PAT_ZEROS, ACC_PAT_ONES, ACC_PAT_TOGGLE,
    ACC_PAT_RAMP, ACC_PAT_CUSTOM, ACC_PAT_RSV6, ACC_PAT_RSV7
  } acc_pat_t;
  typedef struct packed {
    logic dither_off;
    logic power_down;
    logic gain_en;
    logic chop_off;
    logic [2:0] gain_db;
    acc_pat_t pattern;
  } acc_chan_t;
  typedef struct packed {
    logic global_pd;
    logic standby;
    logic pin_to_standby;
    logic offset_binary;
    logic frame_ref_buffer_disable;
    logic low_freq_mode;
    logic over_range_lsb;
    logic [7:0] lvds_swing;
    logic test_en;
    logic test_align;
    logic [13:0] custom_word;
    logic [2:0] clk_div;
  } acc_glob_t;
endpackage

// ---- acc_config_control_tb.sv ----
// Self-checking bench for the converter configuration block.
// Assumes acc_defs.svh, acc_pkg and acc_config_control compiled first.
`include "acc_defs.svh"
module acc_config_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic push = 1'b0, pdpin = 1'b0;
  logic [27:0] s_in = {14'h3ff0, 14'h0100};
  logic [27:0] s_out;
  logic [1:0] range_flag = 2'h0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] s_valid, dith, chop, powered;
  logic s_en, chip_pd, frb, lfm;
  logic [7:0] swing;
  int error_cnt = 0;
  int tests_run = 0;

  initial begin
    forever #4 aclk = ~aclk;
  end

  acc_config_control DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reset_pushbutton(push), .power_down_pin(pdpin),
    .sample_in(s_in), .over_range_flag(range_flag), .sample_en(s_en),
    .sample_out(s_out), .sample_valid(s_valid), .dither_en(dith),
    .chopper_en(chop), .chan_powered(powered),
    .chip_power_down(chip_pd), .frame_ref_buffer_disable(frb),
    .low_freq_mode(lfm), .lvds_swing(swing)
  );

  task automatic tally_and_finish;
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic check_word(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_resp(input string nm, input logic [1:0] e, g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) error_cnt++;
    // Spare edge so the next call never reassigns in this time step
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) error_cnt++;
    @(posedge aclk);
  endtask

  // Plain write; outputs follow config one cycle after the update
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check_resp("bresp", `ACC_RESP_OKAY, r);
    tick(2);
  endtask

  // Several sample strobes flush the pipeline with the new config
  task automatic settle;
    int n;
    n = 0;
    repeat (3) begin
      do begin
        @(posedge aclk);
        n++;
      end while (!s_en && n < 300);
    end
  endtask

  task automatic samp(input string nm, input logic [27:0] e);
    settle();
    @(posedge aclk);
    check_word(nm, 32'(e), 32'(s_out));
  endtask

  initial begin
    int n;
    logic [13:0] e;
    tick(4);
    aresetn <= 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      rdr(8'(i * 4), rd, rs);
      check_word("reset value", 32'h0, rd);
    end
    check_word("dither_en", 32'h3, 32'(dith));
    check_word("chopper_en", 32'h3, 32'(chop));
    check_word("chip_power_down", 32'h0, 32'(chip_pd));
    check_word("buffer_disable", 32'h0, 32'(frb));
    w(`ACC_OFF_GLOBAL, 32'h22);
    check_word("chip_power_down", 32'h1, 32'(chip_pd));
    check_word("buffer_disable", 32'h1, 32'(frb));
    w(`ACC_OFF_GLOBAL, 32'h04);
    check_word("standby powered", 32'h0, 32'(powered));
    check_word("standby chip", 32'h0, 32'(chip_pd));
    w(`ACC_OFF_GLOBAL, 32'h00);
    pdpin <= 1'b1;
    tick(3);
    check_word("pin global", 32'h1, 32'(chip_pd));
    w(`ACC_OFF_GLOBAL, 32'h08);
    check_word("pin standby chip", 32'h0, 32'(chip_pd));
    check_word("pin standby ch", 32'h0, 32'(powered));
    pdpin <= 1'b0;
    w(`ACC_OFF_GLOBAL, 32'h00);
    w(`ACC_OFF_CHAN0, 32'h0b);
    check_word("dither_en", 32'h2, 32'(dith));
    check_word("chopper_en", 32'h2, 32'(chop));
    rdr(`ACC_OFF_STATUS, rd, rs);
    check_word("status powered", 32'h2, 32'(rd[1:0]));
    samp("one channel down", {14'h3ff0, 14'h0000});
    check_word("sample_valid", 32'h2, 32'(s_valid));
    w(`ACC_OFF_CHAN0, 32'h060);
    samp("gain disabled", s_in);
    w(`ACC_OFF_CHAN0, 32'h004);
    samp("gain 0 dB", s_in);
    w(`ACC_OFF_CHAN0, 32'h064);
    settle();
    @(posedge aclk);
    check_word("gain 6 dB", 32'h1, 32'(s_out[13:0] > 14'h0100 &&
               s_out[13:0] <= 14'h0200));
    w(`ACC_OFF_CHAN0, 32'h000);
    w(`ACC_OFF_GLOBAL, 32'h10);
    samp("offset binary", {14'h1ff0, 14'h2100});
    w(`ACC_OFF_GLOBAL, 32'h00);
    w(`ACC_OFF_MISC, 32'h0000a501);
    check_word("low_freq_mode", 32'h1, 32'(lfm));
    check_word("lvds_swing", 32'ha5, 32'(swing));
    // Only byte 1 enabled: swing changes, low byte must be kept
    wstrb <= 4'h2;
    w(`ACC_OFF_MISC, 32'h00003c00);
    check_word("strobe swing", 32'h3c, 32'(swing));
    check_word("strobe keeps lfm", 32'h1, 32'(lfm));
    wstrb <= 4'hf;
    range_flag <= 2'b01;
    w(`ACC_OFF_MISC, 32'h02);
    samp("range flag on lsb", {14'h3ff0, 14'h0101});
    w(`ACC_OFF_MISC, 32'h00);
    range_flag <= 2'b00;
    w(`ACC_OFF_TEST, 32'h00032a5c);
    for (int p = 0; p < 8; p++) begin
      w(`ACC_OFF_CHAN0, 32'(p) << 8);
      w(`ACC_OFF_CHAN1, 32'(p) << 8);
      settle();
      @(posedge aclk);
      case (p)
        1: e = 14'h0000;
        2: e = 14'h3fff;
        5: e = 14'h2a5c;
        default: e = 14'h0100;
      endcase
      if (p == 3 || p == 4) begin
        check_word("aligned", 32'(s_out[27:14]), 32'(s_out[13:0]));
        // Toggle inverts and ramp counts up on every sample strobe
        e = (p == 3) ? ~s_out[13:0] : s_out[13:0] + 14'h1;
        @(posedge aclk);
        check_word("pattern step", 32'(e), 32'(s_out[13:0]));
      end else begin
        check_word("pattern", 32'(e), 32'(s_out[13:0]));
      end
    end
    // A non-normal pattern must not show once test mode is off
    w(`ACC_OFF_CHAN0, 32'h200);
    w(`ACC_OFF_TEST, 32'h00002a5c);
    samp("test disabled", s_in);
    w(`ACC_OFF_CHAN0, 32'h0);
    w(`ACC_OFF_CHAN1, 32'h0);
    w(`ACC_OFF_CLKDIV, 32'h3);
    settle();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_en && n < 50);
    check_word("divider period", 32'h4, 32'(n));
    w(`ACC_OFF_CLKDIV, 32'h0);
    w(`ACC_OFF_CHAN1, 32'h0f);
    w(`ACC_OFF_GLOBAL, 32'h01);
    tick(3);
    rdr(`ACC_OFF_CHAN1, rd, rs);
    check_word("soft reset chan", 32'h0, rd);
    rdr(`ACC_OFF_GLOBAL, rd, rs);
    check_word("soft reset clears", 32'h0, rd);
    check_word("soft reset dither", 32'h3, 32'(dith));
    w(`ACC_OFF_CHAN1, 32'h01);
    push <= 1'b1;
    tick(1);
    push <= 1'b0;
    tick(3);
    rdr(`ACC_OFF_CHAN1, rd, rs);
    check_word("button reset chan", 32'h0, rd);
    check_word("button dither", 32'h3, 32'(dith));
    wr(8'h20, 32'h1, rs);
    check_resp("unmapped write", `ACC_RESP_SLVERR, rs);
    wr(8'h02, 32'h1, rs);
    check_resp("unaligned write", `ACC_RESP_SLVERR, rs);
    wr(`ACC_OFF_STATUS, 32'h1, rs);
    check_resp("read-only write", `ACC_RESP_SLVERR, rs);
    rdr(8'h20, rd, rs);
    check_resp("unmapped read", `ACC_RESP_SLVERR, rs);
    check_word("unmapped data", 32'h0, rd);
    tally_and_finish();
  end

  // The tests need well under 20k cycles
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // acc_config_control_tb
